// File: hw/trb_pkg.sv
/* Constants and carrier types for the transfer request block decoder.
   Assumes one 10 MHz clock and an AXI4-Lite register port with 32-bit data.
// How it works
// - Block type and cycle flag decode in place for any block type.
// - A work item is a group of consecutive blocks joined by chain flags.
// - A zero length hides the pointer words, whatever the immediate flag says.
// - Words 0 and 1 hold the pointer; word 2 holds length, remainder, interrupter.
// - Words 0-1 are a 64-bit address, or eight inline bytes when immediate.
// - Buffer addresses of any byte alignment are accepted unchanged.
// - Outbound blocks send exactly the length in word 2 bits 16 to 0.
// - A length of zero at fetch makes a zero-length transaction.
// - Inbound blocks treat the length as receive buffer size.
// - Word 2 bits 21 to 17 carry the remaining-packet indicator.
// - Word 2 bits 31 to 22 pick the interrupter; out-of-range is flagged.
// - Word 3 decodes into type, event block, immediate, completion, chain and more.
// - Cycle flag in word 3 bit 0 must match ring cycle to own the block.
// - Chain flag set links to the next block; clear ends the group.
// - Completion flag on finish posts an event, interrupt unless blocked.
*/
package trb_pkg;
  localparam logic [7:0]  DWORD0_OFFSET    = 8'h00;
  localparam logic [7:0]  DWORD1_OFFSET    = 8'h04;
  localparam logic [7:0]  DWORD2_OFFSET    = 8'h08;
  localparam logic [7:0]  DWORD3_OFFSET    = 8'h0c;
  localparam logic [7:0]  CONTROL_OFFSET   = 8'h10;
  localparam logic [7:0]  STATUS_OFFSET    = 8'h14;
  localparam logic [7:0]  POINTER_OFFSET   = 8'h18;
  localparam logic [7:0]  TARGET_OFFSET    = 8'h1c;
  localparam int          CTRL_SUBMIT_BIT  = 0;
  localparam int          CTRL_DIR_IN_BIT  = 1;
  localparam int          CTRL_CYCLE_BIT   = 2;
  localparam logic [2:0]  CONTROL_RESET    = 3'h0;
  localparam logic [16:0] MAX_LENGTH       = 17'h10000;
  localparam logic [16:0] MAX_IMM_LENGTH   = 17'h00008;
  localparam logic [16:0] WINDOW_BYTES     = 17'h10000;
  localparam int          INTERRUPTER_COUNT = 8;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef struct packed {
    logic [63:0] pointer;
    logic [63:0] payload;
    logic [16:0] length;
    logic [4:0]  remaining;
    logic [9:0]  interrupter;
    logic [5:0]  block_type;
    logic        event_interrupt_block_flag;
    logic        immediate_payload_flag;
    logic        completion_interrupt_flag;
    logic        chain_flag;
    logic        no_snoop_flag;
    logic        short_packet_interrupt_flag;
    logic        evaluate_next_flag;
    logic        cycle_flag;
    logic        zero_length;
    logic        direction_in;
  } decoded_block_s;

  typedef struct packed {
    logic length_error;
    logic interrupter_error;
    logic immediate_length_error;
    logic window_error;
  } field_errors_s;
endpackage

// File: hw/block_store.sv
/* Staging memory for the four words of one transfer request block.
   Assumes a single writer and a single reader on the same clock. */
`timescale 1ns/100ps
module block_store #(
  parameter int WORDS = 4
) (
  input  wire logic                     sys_clk,
  input  wire logic                     reset_n,
  input  wire logic                     write_enable,
  input  wire logic [$clog2(WORDS)-1:0] write_index,
  input  wire logic [31:0]              write_data,
  input  wire logic [$clog2(WORDS)-1:0] read_index,
  output logic      [31:0]              read_data
);
  logic [31:0] words [WORDS];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      read_data <= 32'h0;
      for (int i = 0; i < WORDS; i++) begin
        words[i] <= 32'h0;
      end
    end else begin
      read_data <= words[read_index];
      if (write_enable) begin
        words[write_index] <= write_data;
      end
    end
  end
endmodule // block_store

// File: hw/field_check.sv
/* Registered range checks on the decoded fields of one block.
   Assumes its inputs stay steady for the cycle after they are presented. */
`timescale 1ns/100ps
module field_check #(
  parameter int INTERRUPTERS = trb_pkg::INTERRUPTER_COUNT
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire trb_pkg::decoded_block_s block,
  output trb_pkg::field_errors_s     errors
);
  trb_pkg::field_errors_s next_errors;
  logic [17:0]            window_end;

  always_comb begin
    window_end = {2'b0, block.pointer[15:0]} + {1'b0, block.length};
    next_errors.length_error = block.length > trb_pkg::MAX_LENGTH;
    next_errors.interrupter_error =
      {22'h0, block.interrupter} >= 32'(INTERRUPTERS);
    next_errors.immediate_length_error = block.immediate_payload_flag &&
      (block.length > trb_pkg::MAX_IMM_LENGTH);
    // A crossing is a software fault; the block is refused rather than split here.
    next_errors.window_error = !block.immediate_payload_flag && !block.zero_length &&
      (window_end > {1'b0, trb_pkg::WINDOW_BYTES});
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      errors <= '0;
    end else begin
      errors <= next_errors;
    end
  end
endmodule // field_check

// File: hw/trb_decoder.sv
/* Fetches one staged transfer request block, decodes it and hands it to the
   transfer engine, then posts the completion event if the completion or short-packet flag asks for one.
   Assumes the engine shares sys_clk and pulses engine_done once per block. */
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/100ps
module trb_decoder #(
  parameter int INTERRUPTERS = trb_pkg::INTERRUPTER_COUNT
) (
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output trb_pkg::decoded_block_s     out_block,
  output logic                        out_valid,
  input  wire logic                   out_ready,
  input  wire logic                   engine_done,
  input  wire logic                   engine_short,
  output logic                        event_post,
  output logic                        event_interrupt,
  output logic [9:0]                  event_interrupter
);
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_FETCH = 5'h02,
    ST_CHECK = 5'h04,
    ST_OFFER = 5'h08,
    ST_RUN   = 5'h10
  } decode_state_e;

  decode_state_e           state, next_state;
  logic [2:0]              fetch_idx, next_fetch_idx;
  logic [31:0]             dw [4];
  logic [31:0]             next_dw [4];
  logic [2:0]              control, next_control;
  logic                    submit, next_submit;
  logic                    not_owned, next_not_owned;
  logic                    group_end, next_group_end;
  logic [7:0]              group_count, next_group_count;
  trb_pkg::decoded_block_s decoded, check_in, next_out_block;
  trb_pkg::field_errors_s  errors, err_latched, next_err_latched;
  logic                    next_out_valid, next_event_post, next_event_interrupt;
  logic [9:0]              next_event_interrupter;
  logic [31:0]             mem_rdata;
  logic                    mem_we;
  logic [1:0]              mem_windex;

  logic                    aw_have, next_aw_have, w_have, next_w_have;
  logic [7:0]              aw_addr, next_aw_addr;
  logic [31:0]             w_data, next_w_data;
  logic [3:0]              w_strb, next_w_strb;
  logic                    next_awready, next_wready, next_bvalid;
  logic [1:0]              next_bresp;
  logic                    next_arready, next_rvalid;
  logic [31:0]             next_rdata;
  logic [1:0]              next_rresp;

  block_store #(.WORDS(4)) u_store (
    .sys_clk      (sys_clk),
    .reset_n      (reset_n),
    .write_enable (mem_we),
    .write_index  (mem_windex),
    .write_data   (next_w_data),
    .read_index   (fetch_idx[1:0]),
    .read_data    (mem_rdata)
  );

  field_check #(.INTERRUPTERS(INTERRUPTERS)) u_check (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .block   (check_in),
    .errors  (errors)
  );

  // Decoding is pure wiring from the words; reserved-zero bits are never read.
  function automatic trb_pkg::decoded_block_s decode_words(input logic [31:0] w0, w1, w2, w3,
                                                           input logic        dir);
    trb_pkg::decoded_block_s b;
    b.length      = w2[16:0];
    b.remaining   = w2[21:17];
    b.interrupter = w2[31:22];
    b.zero_length = (w2[16:0] == 17'h0);
    b.block_type  = w3[15:10];
    b.event_interrupt_block_flag  = w3[9];
    b.immediate_payload_flag      = w3[6];
    b.completion_interrupt_flag   = w3[5];
    b.chain_flag                  = w3[4];
    b.no_snoop_flag               = w3[3];
    b.short_packet_interrupt_flag = w3[2];
    b.evaluate_next_flag          = w3[1];
    b.cycle_flag                  = w3[0];
    b.direction_in                = dir;
    // Pointer words are hidden on zero length; no alignment is imposed.
    b.pointer = 64'h0;
    b.payload = 64'h0;
    if (!b.zero_length) begin
      if (b.immediate_payload_flag) begin
        b.payload = {w1, w0};
      end else begin
        b.pointer = {w1, w0};
      end
    end
    return b;
  endfunction

  assign decoded = decode_words(dw[0], dw[1], dw[2], dw[3], control[trb_pkg::CTRL_DIR_IN_BIT]);
  // The range checks register their result, so they watch the words as they land;
  // fed from the captured words they would judge word 3 of the previous block.
  assign check_in = decode_words(next_dw[0], next_dw[1], next_dw[2], next_dw[3],
                                 control[trb_pkg::CTRL_DIR_IN_BIT]);

  // Register bus: address and data may arrive in either order.
  always_comb begin
    next_aw_have = aw_have;
    next_aw_addr = aw_addr;
    next_w_have  = w_have;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid && !s_axi_bready;
    next_bresp   = s_axi_bresp;
    next_control = control;
    next_submit  = 1'b0;
    mem_we       = 1'b0;
    mem_windex   = 2'h0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_have = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_have = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (next_aw_have && next_w_have && !next_bvalid) begin
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = trb_pkg::RESP_OKAY;
      mem_windex   = next_aw_addr[3:2];
      if (next_aw_addr < trb_pkg::CONTROL_OFFSET && next_aw_addr[1:0] == 2'h0) begin
        // Staging words cannot change under a block being decoded.
        mem_we = (state == ST_IDLE) && (next_w_strb == 4'hf);
        if (!mem_we) begin
          next_bresp = trb_pkg::RESP_SLVERR;
        end
      end else if (next_aw_addr == trb_pkg::CONTROL_OFFSET) begin
        if (next_w_strb[0]) begin
          next_control = next_w_data[2:0];
          next_submit  = next_w_data[trb_pkg::CTRL_SUBMIT_BIT] && (state == ST_IDLE);
        end
      end else begin
        next_bresp = trb_pkg::RESP_SLVERR;
      end
    end
    next_awready = !next_aw_have && !next_bvalid;
    next_wready  = !next_w_have && !next_bvalid;
  end

  always_comb begin
    next_rvalid  = s_axi_rvalid && !s_axi_rready;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = trb_pkg::RESP_OKAY;
      case (s_axi_araddr)
        trb_pkg::DWORD0_OFFSET, trb_pkg::DWORD1_OFFSET,
        trb_pkg::DWORD2_OFFSET, trb_pkg::DWORD3_OFFSET: begin
          next_rdata = dw[s_axi_araddr[3:2]];
        end
        trb_pkg::CONTROL_OFFSET: next_rdata = {29'h0, control};
        trb_pkg::STATUS_OFFSET: begin
          next_rdata = {16'h0, group_count, err_latched, group_end, not_owned,
                        (state != ST_IDLE), (state == ST_IDLE)};
        end
        trb_pkg::POINTER_OFFSET: next_rdata = dw[2];
        trb_pkg::TARGET_OFFSET: next_rdata = {22'h0, event_interrupter};
        default: begin
          next_rdata = 32'h0;
          next_rresp = trb_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_arready = !next_rvalid;
  end

  // Fetch, check, offer and completion sequence.
  always_comb begin
    next_state            = state;
    next_fetch_idx        = fetch_idx;
    for (int i = 0; i < 4; i++) begin
      next_dw[i] = dw[i];
    end
    next_not_owned        = not_owned;
    next_group_end        = group_end;
    next_group_count      = group_count;
    next_err_latched      = err_latched;
    next_out_block        = out_block;
    next_out_valid        = out_valid && !out_ready;
    next_event_post       = 1'b0;
    next_event_interrupt  = 1'b0;
    next_event_interrupter = event_interrupter;
    case (state)
      ST_IDLE: begin
        if (submit) begin
          next_state     = ST_FETCH;
          next_fetch_idx = 3'h0;
        end
      end
      ST_FETCH: begin
        next_fetch_idx = fetch_idx + 3'h1;
        if (fetch_idx != 3'h0) begin
          next_dw[fetch_idx[1:0] - 2'h1] = mem_rdata;
        end
        if (fetch_idx == 3'h4) begin
          next_dw[3] = mem_rdata;
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        next_err_latched = errors;
        next_not_owned = decoded.cycle_flag != control[trb_pkg::CTRL_CYCLE_BIT];
        if (next_not_owned || (errors != '0)) begin
          next_state = ST_IDLE;
        end else begin
          next_out_block = decoded;
          next_out_valid = 1'b1;
          next_state     = ST_OFFER;
        end
      end
      ST_OFFER: begin
        if (out_ready) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (engine_done) begin
          next_state = ST_IDLE;
          // One event only, even when short and completion both apply.
          next_event_post = out_block.completion_interrupt_flag ||
            (engine_short && out_block.short_packet_interrupt_flag);
          next_event_interrupt = next_event_post &&
            !out_block.event_interrupt_block_flag;
          next_event_interrupter = out_block.interrupter;
          next_group_end   = !out_block.chain_flag;
          next_group_count = out_block.chain_flag ? group_count + 8'h1 : 8'h0;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      fetch_idx <= 3'h0;
      for (int i = 0; i < 4; i++) begin
        dw[i] <= 32'h0;
      end
      control <= trb_pkg::CONTROL_RESET;
      submit <= 1'b0;
      not_owned <= 1'b0;
      group_end <= 1'b0;
      group_count <= 8'h0;
      err_latched <= '0;
      out_block <= '0;
      out_valid <= 1'b0;
      event_post <= 1'b0;
      event_interrupt <= 1'b0;
      event_interrupter <= 10'h0;
      aw_have <= 1'b0;
      aw_addr <= 8'h0;
      w_have <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      state <= next_state;
      fetch_idx <= next_fetch_idx;
      for (int i = 0; i < 4; i++) begin
        dw[i] <= next_dw[i];
      end
      control <= next_control;
      submit <= next_submit;
      not_owned <= next_not_owned;
      group_end <= next_group_end;
      group_count <= next_group_count;
      err_latched <= next_err_latched;
      out_block <= next_out_block;
      out_valid <= next_out_valid;
      event_post <= next_event_post;
      event_interrupt <= next_event_interrupt;
      event_interrupter <= next_event_interrupter;
      aw_have <= next_aw_have;
      aw_addr <= next_aw_addr;
      w_have <= next_w_have;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  chk_offer_holds: assert property (out_valid && !out_ready |=> out_valid && $stable(out_block))
    else $error("offered block dropped or changed before it was taken");
  chk_zero_hides: assert property (out_valid && out_block.zero_length |->
    out_block.pointer == 64'h0 && out_block.payload == 64'h0)
    else $error("pointer words leaked on a zero-length block");
  chk_length_field: assert property (out_valid |-> out_block.length == dw[2][16:0] &&
    out_block.zero_length == (dw[2][16:0] == 17'h0))
    else $error("length field not taken from word 2 bits 16 to 0");
  chk_remaining_field: assert property (out_valid |-> out_block.remaining == dw[2][21:17])
    else $error("remaining-packet field mis-decoded");
  chk_interrupter_range: assert property (out_valid |->
    {22'h0, out_block.interrupter} < 32'(INTERRUPTERS))
    else $error("out-of-range interrupter offered to the engine");
  chk_cycle_owned: assert property (out_valid |->
    out_block.cycle_flag == control[trb_pkg::CTRL_CYCLE_BIT])
    else $error("block offered without ownership");
  chk_immediate_split: assert property (out_valid && !out_block.zero_length |->
    (out_block.immediate_payload_flag ? out_block.payload : out_block.pointer) == {dw[1], dw[0]})
    else $error("words 0 and 1 routed to the wrong field");
  chk_type_in_place: assert property (out_valid |-> out_block.block_type == dw[3][15:10] &&
    out_block.chain_flag == dw[3][4] && out_block.event_interrupt_block_flag == dw[3][9])
    else $error("word 3 fields mis-decoded");
  chk_completion_event: assert property (state == ST_RUN && engine_done &&
    out_block.completion_interrupt_flag |=> event_post &&
    event_interrupt == !out_block.event_interrupt_block_flag)
    else $error("completion event missing or interrupt wrong");
  chk_group_end: assert property (state == ST_RUN && engine_done && !out_block.chain_flag
    |=> group_end && group_count == 8'h0)
    else $error("group did not end on a clear chain flag");
  chk_fetch_time: assert property ($rose(state == ST_FETCH) |-> ##5 state == ST_CHECK)
    else $error("fetch of four words took the wrong number of cycles");

  cov_block_taken: cover property (out_valid && out_ready);
  cov_event_posted: cover property (event_post && event_interrupt);
  cov_not_owned: cover property ($rose(not_owned));
  cov_zero_length: cover property (out_valid && out_block.zero_length);
endmodule // trb_decoder

// File: verif/engine_model.sv
/* Behavioural transfer engine that takes decoded blocks from the decoder.
   Assumes it shares sys_clk with the decoder; delay sets how long a block takes. */
`timescale 1ns/100ps
module engine_model (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       out_valid,
  input  wire logic [3:0] delay,
  input  wire logic       short_req,
  output logic            out_ready,
  output logic            engine_done,
  output logic            engine_short
);
  logic       busy;
  logic [3:0] count;

  // Ready lags valid by a cycle, so the decoder must hold its offer meanwhile.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_ready <= 1'b0;
      engine_done <= 1'b0;
      engine_short <= 1'b0;
      busy <= 1'b0;
      count <= 4'h0;
    end else begin
      engine_done <= 1'b0;
      // The short flag only means something with done, so elsewhere it shows the opposite.
      engine_short <= ~short_req;
      if (busy) begin
        count <= count - 4'h1;
        if (count == 4'h0) begin
          busy <= 1'b0;
          engine_done <= 1'b1;
          engine_short <= short_req;
        end
      end else if (out_valid && out_ready) begin
        out_ready <= 1'b0;
        busy <= 1'b1;
        count <= delay;
      end else begin
        out_ready <= out_valid;
      end
    end
  end
endmodule // engine_model

// File: verif/trb_decoder_tb.sv
/* Self-checking bench for the block decoder, one task per scenario.
   Assumes trb_pkg and the engine model; registers are reached over AXI4-Lite. */
`timescale 1ns/100ps
module trb_decoder_tb;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [31:0] wd = 32'h0, rd;
  logic [3:0]  ws = 4'hf, delay = 4'hc;
  logic        awr, wr, bv, arr, rv, ov, ordy, done, shrt, ep, ei, sreq = 1'b0;
  logic [1:0]  br, rr;
  logic [9:0]  eit;
  int          error_cnt = 0, compares = 0;
  trb_pkg::decoded_block_s ob;

  always #50 sys_clk = ~sys_clk;

  trb_decoder DUT (.sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .out_block(ob), .out_valid(ov), .out_ready(ordy),
    .engine_done(done), .engine_short(shrt), .event_post(ep), .event_interrupt(ei),
    .event_interrupter(eit));
  engine_model EM (.sys_clk(sys_clk), .reset_n(reset_n), .out_valid(ov), .delay(delay),
    .short_req(sreq), .out_ready(ordy), .engine_done(done), .engine_short(shrt));

  task check(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    int n;
    n = 0;
    @(posedge sys_clk);
    awa <= a; wd <= d; ws <= s; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!bv && n < 50);
    bre <= 1'b0;
    check("write response", {1'b1, e}, {bv, br});
  endtask

  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (arv && arr) arv <= 1'b0;
    end while (!rv && n < 50);
    rre <= 1'b0;
    d = rd;
    r = rv ? rr : 2'h3;
  endtask

  task load(input logic [31:0] w0, w1, w2, w3, input logic dir);
    axw(trb_pkg::DWORD0_OFFSET, w0, 4'hf, trb_pkg::RESP_OKAY);
    axw(trb_pkg::DWORD1_OFFSET, w1, 4'hf, trb_pkg::RESP_OKAY);
    axw(trb_pkg::DWORD2_OFFSET, w2, 4'hf, trb_pkg::RESP_OKAY);
    axw(trb_pkg::DWORD3_OFFSET, w3, 4'hf, trb_pkg::RESP_OKAY);
    axw(trb_pkg::CONTROL_OFFSET, {29'h0, 1'b1, dir, 1'b1}, 4'hf, trb_pkg::RESP_OKAY);
  endtask

  task run_good(input logic [31:0] w0, w1, w2, w3, input logic dir, sh);
    int n;
    logic [63:0] p;
    logic z, post;
    sreq <= sh;
    load(w0, w1, w2, w3, dir);
    n = 0;
    do begin @(posedge sys_clk); n++; end while (!ov && n < 40);
    z = (w2[16:0] == 17'h0);
    p = z ? 64'h0 : {w1, w0};
    post = w3[5] | (w3[2] & sh);
    check("offer", 1'b1, ov);
    if (z || !w3[6]) check("pointer", p, ob.pointer);
    if (z || w3[6]) check("payload", p, ob.payload);
    check("length fields", {w2, z}, {ob.interrupter, ob.remaining, ob.length, ob.zero_length});
    check("flags", {w3[15:9], w3[6:0], dir}, {ob.block_type, ob.event_interrupt_block_flag,
      ob.immediate_payload_flag, ob.completion_interrupt_flag, ob.chain_flag, ob.no_snoop_flag,
      ob.short_packet_interrupt_flag, ob.evaluate_next_flag, ob.cycle_flag, ob.direction_in});
    if (delay > 4'h8) axw(trb_pkg::DWORD0_OFFSET, 32'h0, 4'hf, trb_pkg::RESP_SLVERR);
    n = 0;
    do begin @(posedge sys_clk); n++; end while (!ep && n < 40);
    check("event", {post, post & ~w3[9]}, {ep, ei});
    if (post) check("event interrupter", w2[31:22], eit);
  endtask

  task run_bad(input logic [31:0] w0, w2, w3, input int b);
    logic [31:0] d;
    logic [1:0] r;
    logic seen;
    seen = 1'b0;
    load(w0, 32'h0, w2, w3, 1'b0);
    repeat (16) begin @(posedge sys_clk); seen |= ov; end
    check("dropped offer", 1'b0, seen);
    axr(trb_pkg::STATUS_OFFSET, d, r);
    check("status flag", 1'b1, d[b]);
  endtask

  task close_out;
    if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #800000;
    error_cnt++;
    close_out;
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    axr(8'h20, d, r);
    check("unmapped read", {trb_pkg::RESP_SLVERR, 32'h0}, {r, d});
    axw(trb_pkg::DWORD0_OFFSET, 32'h1, 4'h3, trb_pkg::RESP_SLVERR);
    run_good(32'h1234_5673, 32'hab, {10'd5, 5'd3, 17'h100}, 32'hffff_05ab, 1'b0, 1'b0);
    axr(trb_pkg::POINTER_OFFSET, d, r);
    check("word 2 copy", {trb_pkg::RESP_OKAY, 10'd5, 5'd3, 17'h100}, {r, d});
    axr(trb_pkg::TARGET_OFFSET, d, r);
    check("event target", {trb_pkg::RESP_OKAY, 32'h5}, {r, d});
    run_good(32'h0, 32'h1, {10'd7, 5'd0, 17'h10000}, 32'h621, 1'b1, 1'b0);
    run_good(32'hffff_ffff, 32'h5, 32'h0, 32'h461, 1'b0, 1'b0);
    delay <= 4'h0;
    run_good(32'h0403_0201, 32'h0807_0605, 32'h8, 32'h451, 1'b0, 1'b0);
    axr(trb_pkg::STATUS_OFFSET, d, r);
    check("chained status", {8'h1, 1'b0, 2'h1}, {d[15:8], d[3], d[1:0]});
    run_good(32'h100, 32'h0, 32'h40, 32'h405, 1'b1, 1'b1);
    axr(trb_pkg::STATUS_OFFSET, d, r);
    check("group end status", {8'h0, 1'b1, 2'h1}, {d[15:8], d[3], d[1:0]});
    run_bad(32'h0, 32'h10, 32'h400, 2);
    run_bad(32'h0, 32'h1_0001, 32'h401, 7);
    run_bad(32'h0, {10'd8, 22'h10}, 32'h401, 6);
    run_bad(32'h0, 32'h9, 32'h441, 5);
    run_bad(32'hfff0, 32'h20, 32'h401, 4);
    close_out;
  end
endmodule // trb_decoder_tb
